// ==== hdl/audio_path_control_decoder.sv ====
// Serial loaded control word and its decode into the audio path select and gain signals.
`timescale 1ns/1ps
module audio_path_control_decoder #(
	parameter int WORD_W = 47 // Serial word length; only the documented length is served.
) (
	// System clock and synchronous reset.
	input wire logic clk_i,
	input wire logic reset_i,
	// Three-wire serial link from the host.
	input wire logic serial_clk_i,
	input wire logic serial_data_i,
	input wire logic chip_sel_n_i,
	// Comparator result, noise above threshold, asynchronous.
	input wire logic noise_above_i,
	// Pre-process path controls.
	output logic mic2_sel_o,
	output logic in_mic_sel_o,
	output logic in_rx_sel_o,
	output logic opamp_en_o,
	output logic [3:0] in_gain_o,
	output logic voice_level_compressor_en_o,
	output logic hp_filter_en_o,
	output logic hp_gain_boost_o,
	output logic lp_filter_en_o,
	output logic [3:0] pre_gain_o,
	// Post-process path controls.
	output logic ext_proc_sel_o,
	output logic preemph_en_o,
	output logic limiter_en_o,
	output logic post_lpf_wide_o,
	output logic post_lpf_en_o,
	output logic [1:0] drive_sel_o,
	output logic deemph_sel_o,
	output logic post_powersave_o,
	output logic [2:0] ref_atten_o,
	output logic [3:0] ref_amp_o,
	output logic out_drive_en_o,
	output logic [3:0] mod_atten_o,
	output logic [3:0] mod_amp_o,
	output logic rx_out_en_o,
	// Squelch system controls.
	output logic [2:0] sq_gain_o,
	output logic sq_wide_o,
	output logic [3:0] sq_thresh_o,
	output logic sq_noise_sel_o,
	output logic sq_rssi_sel_o,
	output logic sq_detect_en_o,
	output logic squelch_drive_o
);

	// The field map is fixed, so any other word length cannot be decoded.
	if (WORD_W != audio_path_pkg::CTRL_W) begin : g_bad_width
		$error("WORD_W must equal the control word length");
	end

	// Shift register on the serial clock; never reset, the host always refills it.
	logic [WORD_W-1:0] shift_ff;
	// Chip select synchroniser into the system clock domain, and its delayed copy.
	logic cs_meta_ff;
	logic cs_sync_ff;
	logic cs_prev_ff;
	// Active control word.
	logic [WORD_W-1:0] ctrl_ff;
	// Comparator synchroniser.
	logic sq_meta_ff;
	logic sq_sync_ff;
	// Rising edge of the synchronised chip select.
	logic latch_word;
	// Field views of the active word.
	logic [1:0] src_code;
	logic [1:0] drv_code;
	logic [1:0] sq_code;
	logic proc_bypass;

	// Bits enter at the bottom, so bit 46 sent first ends at the top. [RULE_23]
	// Shifting only while chip select is low keeps the word still once the frame ends.
	always_ff @(posedge serial_clk_i) begin
		if (!chip_sel_n_i) begin
			shift_ff <= {shift_ff[WORD_W-2:0], serial_data_i}; // [RULE_24]
		end
	end

	// Chip select crosses as a level through two flip-flops.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cs_meta_ff <= audio_path_pkg::CS_IDLE;
			cs_sync_ff <= audio_path_pkg::CS_IDLE;
			cs_prev_ff <= audio_path_pkg::CS_IDLE;
		end else begin
			// Running: the pin level moves one stage along per clock.
			cs_meta_ff <= chip_sel_n_i;
			cs_sync_ff <= cs_meta_ff;
			cs_prev_ff <= cs_sync_ff;
		end
	end

	// The rising edge is seen after the pin has been high for two clocks.
	assign latch_word = cs_sync_ff && !cs_prev_ff;

	// Active word load; the shift register is quiet while chip select is high,
	// so the multi-bit copy is taken from a settled source.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_ff <= audio_path_pkg::CTRL_RESET; // [RULE_28]
		end else if (latch_word) begin
			ctrl_ff <= shift_ff; // [RULE_25]
		end
	end

	// Two-bit selector fields.
	assign src_code = ctrl_ff[audio_path_pkg::B_SRC +: 2];
	assign drv_code = ctrl_ff[audio_path_pkg::B_DRV +: 2];
	assign sq_code = ctrl_ff[audio_path_pkg::B_SQ_SRC +: 2];
	assign proc_bypass = (drv_code == audio_path_pkg::DRV_BYPASS); // [RULE_14]

	// Pre-process input selection and op-amp power.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mic2_sel_o <= 1'h0;
			in_mic_sel_o <= 1'h0;
			in_rx_sel_o <= 1'h0;
			opamp_en_o <= 1'h0;
		end else begin
			// Running: the selects follow the active word one clock later.
			mic2_sel_o <= ctrl_ff[audio_path_pkg::B_MIC]; // [RULE_01]
			in_mic_sel_o <= (src_code == audio_path_pkg::SRC_MIC); // [RULE_02]
			in_rx_sel_o <= (src_code == audio_path_pkg::SRC_RX); // [RULE_02]
			// The op-amp only runs for the transmit microphone path.
			opamp_en_o <= (src_code == audio_path_pkg::SRC_MIC); // [RULE_02]
		end
	end

	// Pre-process gains, compressor and shaping filters.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			in_gain_o <= 4'h0;
			voice_level_compressor_en_o <= 1'h0;
			hp_filter_en_o <= 1'h0;
			hp_gain_boost_o <= 1'h0;
			lp_filter_en_o <= 1'h0;
			pre_gain_o <= 4'h0;
		end else begin
			// Gain codes pass through unchanged; their meaning lives in the analog stages.
			in_gain_o <= ctrl_ff[audio_path_pkg::B_IN_GAIN +: 4]; // [RULE_03]
			// The compressor is not forced off without the highpass; that is the host's duty.
			voice_level_compressor_en_o <= ctrl_ff[audio_path_pkg::B_COMP]; // [RULE_04]
			hp_filter_en_o <= ctrl_ff[audio_path_pkg::B_HP]; // [RULE_06]
			hp_gain_boost_o <= ctrl_ff[audio_path_pkg::B_HP]
				&& (src_code == audio_path_pkg::SRC_MIC); // [RULE_06]
			lp_filter_en_o <= ctrl_ff[audio_path_pkg::B_LP]; // [RULE_06]
			pre_gain_o <= ctrl_ff[audio_path_pkg::B_PRE_GAIN +: 4]; // [RULE_07]
		end
	end

	// Post-process source, emphasis, limiter and lowpass filter.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ext_proc_sel_o <= 1'h0;
			preemph_en_o <= 1'h0;
			limiter_en_o <= 1'h0;
			post_lpf_wide_o <= 1'h0;
			post_lpf_en_o <= 1'h0;
			post_powersave_o <= 1'h0;
		end else begin
			// The process bypass path overrides the individual enable bits here.
			ext_proc_sel_o <= ctrl_ff[audio_path_pkg::B_PROC_SEL]; // [RULE_08]
			preemph_en_o <= ctrl_ff[audio_path_pkg::B_PREEMPH] && !proc_bypass; // [RULE_09]
			limiter_en_o <= !proc_bypass; // [RULE_14]
			post_lpf_wide_o <= ctrl_ff[audio_path_pkg::B_LPF_WIDE]; // [RULE_10]
			post_lpf_en_o <= ctrl_ff[audio_path_pkg::B_LPF_EN] && !proc_bypass; // [RULE_11]
			post_powersave_o <= proc_bypass; // [RULE_14]
		end
	end

	// Output drive selection and de-emphasis.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			drive_sel_o <= 2'h0;
			deemph_sel_o <= 1'h0;
		end else begin
			// The selector code itself is passed on for the analog switch.
			drive_sel_o <= drv_code; // [RULE_12]
			// De-emphasis runs only on the path that goes through it.
			deemph_sel_o <= (drv_code == audio_path_pkg::DRV_DEEMPH); // [RULE_13]
		end
	end

	// Reference and modulator drive stages and the receive output.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ref_atten_o <= 3'h0;
			ref_amp_o <= 4'h0;
			out_drive_en_o <= 1'h0;
			mod_atten_o <= 4'h0;
			mod_amp_o <= 4'h0;
			rx_out_en_o <= 1'h0;
		end else begin
			// Codes pass straight through; bit 27 alone gates both drive outputs.
			ref_atten_o <= ctrl_ff[audio_path_pkg::B_REF_ATT +: 3]; // [RULE_15]
			ref_amp_o <= ctrl_ff[audio_path_pkg::B_REF_AMP +: 4]; // [RULE_27]
			out_drive_en_o <= ctrl_ff[audio_path_pkg::B_OUT_EN]; // [RULE_16]
			mod_atten_o <= ctrl_ff[audio_path_pkg::B_MOD_ATT +: 4]; // [RULE_17]
			mod_amp_o <= ctrl_ff[audio_path_pkg::B_MOD_AMP +: 4]; // [RULE_18]
			rx_out_en_o <= ctrl_ff[audio_path_pkg::B_RX_OUT]; // [RULE_19]
		end
	end

	// Squelch filter, threshold and source.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sq_gain_o <= 3'h0;
			sq_wide_o <= 1'h0;
			sq_thresh_o <= 4'h0;
			sq_noise_sel_o <= 1'h0;
			sq_rssi_sel_o <= 1'h0;
			sq_detect_en_o <= 1'h0;
		end else begin
			// Squelch settings follow the active word one clock later.
			sq_gain_o <= ctrl_ff[audio_path_pkg::B_SQ_GAIN +: 3]; // [RULE_20]
			sq_wide_o <= ctrl_ff[audio_path_pkg::B_SQ_WIDE]; // [RULE_20]
			sq_thresh_o <= ctrl_ff[audio_path_pkg::B_SQ_THR +: 4]; // [RULE_21]
			// The reserved code is treated as the bias path so nothing is driven.
			sq_noise_sel_o <= (sq_code == audio_path_pkg::SQ_NOISE); // [RULE_22]
			sq_rssi_sel_o <= (sq_code == audio_path_pkg::SQ_RSSI); // [RULE_22]
			sq_detect_en_o <= (sq_code == audio_path_pkg::SQ_NOISE)
				|| (sq_code == audio_path_pkg::SQ_RSSI); // [RULE_22]
		end
	end

	// Comparator level crosses through two flip-flops, then drives the pin.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sq_meta_ff <= 1'h0;
			sq_sync_ff <= 1'h0;
			squelch_drive_o <= 1'h0;
		end else begin
			// A third stage registers the level so the pin comes from a flip-flop.
			sq_meta_ff <= noise_above_i;
			sq_sync_ff <= sq_meta_ff;
			squelch_drive_o <= sq_sync_ff; // [RULE_26]
		end
	end

	// A chip select rise loads the shifted word and nothing else changes it.
	property p_latch;
		@(posedge clk_i) disable iff (reset_i)
		!latch_word |=> $stable(ctrl_ff);
	endproperty
	a_latch: assert property (p_latch) else $error("Active word changed without latch"); // [RULE_25]

	// Outputs follow a latch two clocks later.
	property p_mod_att;
		@(posedge clk_i) disable iff (reset_i)
		latch_word |=> ##1 mod_atten_o == ctrl_ff[audio_path_pkg::B_MOD_ATT +: 4];
	endproperty
	a_mod_att: assert property (p_mod_att) else $error("Modulator attenuation not decoded"); // [RULE_17]

	// The op-amp enable follows the source code.
	property p_opamp;
		@(posedge clk_i) disable iff (reset_i)
		opamp_en_o == (($past(src_code) == audio_path_pkg::SRC_MIC) && $past(!reset_i));
	endproperty
	a_opamp: assert property (p_opamp) else $error("Op-amp enable wrong"); // [RULE_02]

	// Pre-emphasis is never on under process bypass.
	property p_preemph;
		@(posedge clk_i) disable iff (reset_i)
		drive_sel_o == audio_path_pkg::DRV_BYPASS |-> !preemph_en_o && !post_lpf_en_o
			&& post_powersave_o;
	endproperty
	a_preemph: assert property (p_preemph) else $error("Bypass did not powersave"); // [RULE_09]

	// De-emphasis select only on the via-de-emphasis path.
	property p_deemph;
		@(posedge clk_i) disable iff (reset_i)
		deemph_sel_o == (drive_sel_o == audio_path_pkg::DRV_DEEMPH);
	endproperty
	a_deemph: assert property (p_deemph) else $error("De-emphasis select wrong"); // [RULE_13]

	// Highpass boost only with the filter on and the microphone chosen.
	property p_boost;
		@(posedge clk_i) disable iff (reset_i)
		hp_gain_boost_o |-> hp_filter_en_o && in_mic_sel_o;
	endproperty
	a_boost: assert property (p_boost) else $error("Highpass boost without microphone"); // [RULE_06]

	// The detector never runs on the bias or reserved code.
	property p_sq_src;
		@(posedge clk_i) disable iff (reset_i)
		sq_detect_en_o == (sq_noise_sel_o ^ sq_rssi_sel_o);
	endproperty
	a_sq_src: assert property (p_sq_src) else $error("Squelch detector enable wrong"); // [RULE_22]

	// Squelch drive follows the comparator three clocks later.
	property p_sqd;
		@(posedge clk_i) disable iff (reset_i)
		$rose(noise_above_i) ##1 noise_above_i[*2] |=> squelch_drive_o;
	endproperty
	a_sqd: assert property (p_sqd) else $error("Squelch drive did not follow"); // [RULE_26]

	// After reset the modulation drive and receive outputs stay off until the first latch.
	property p_reset;
		@(posedge clk_i)
		reset_i ##1 !latch_word[*2] |-> !out_drive_en_o && !rx_out_en_o;
	endproperty
	a_reset: assert property (p_reset) else $error("Outputs enabled after reset"); // [RULE_28]

	// Receive input select follows the source code one clock after the word.
	property p_rx_sel;
		@(posedge clk_i) disable iff (reset_i)
		in_rx_sel_o == ($past(src_code) == audio_path_pkg::SRC_RX);
	endproperty
	a_rx_sel: assert property (p_rx_sel) else $error("Receive select wrong"); // [RULE_02]

	// Input gain code is passed on one clock after the word.
	property p_in_gain;
		@(posedge clk_i) disable iff (reset_i)
		in_gain_o == $past(ctrl_ff[audio_path_pkg::B_IN_GAIN +: 4]);
	endproperty
	a_in_gain: assert property (p_in_gain) else $error("Input gain wrong"); // [RULE_03]

	// Pre-process gain code is passed on one clock after the word.
	property p_pre_gain;
		@(posedge clk_i) disable iff (reset_i)
		pre_gain_o == $past(ctrl_ff[audio_path_pkg::B_PRE_GAIN +: 4]);
	endproperty
	a_pre_gain: assert property (p_pre_gain) else $error("Pre gain wrong"); // [RULE_07]

	// The limiter runs on every drive path but the process bypass.
	property p_limiter;
		@(posedge clk_i) disable iff (reset_i)
		limiter_en_o == (($past(drv_code) != audio_path_pkg::DRV_BYPASS) && $past(!reset_i));
	endproperty
	a_limiter: assert property (p_limiter) else $error("Limiter enable wrong"); // [RULE_14]

	// Both modulation drive outputs follow the output control bit.
	property p_out_en;
		@(posedge clk_i) disable iff (reset_i)
		out_drive_en_o == $past(ctrl_ff[audio_path_pkg::B_OUT_EN]);
	endproperty
	a_out_en: assert property (p_out_en) else $error("Drive enable wrong"); // [RULE_16]

	// The receive output follows its enable bit.
	property p_rx_out;
		@(posedge clk_i) disable iff (reset_i)
		rx_out_en_o == $past(ctrl_ff[audio_path_pkg::B_RX_OUT]);
	endproperty
	a_rx_out: assert property (p_rx_out) else $error("Receive output wrong"); // [RULE_19]

	// Squelch threshold code is passed on one clock after the word.
	property p_sq_thr;
		@(posedge clk_i) disable iff (reset_i)
		sq_thresh_o == $past(ctrl_ff[audio_path_pkg::B_SQ_THR +: 4]);
	endproperty
	a_sq_thr: assert property (p_sq_thr) else $error("Squelch threshold wrong"); // [RULE_21]

	// Noise source select follows the squelch source code.
	property p_sq_sel;
		@(posedge clk_i) disable iff (reset_i)
		sq_noise_sel_o == ($past(sq_code) == audio_path_pkg::SQ_NOISE);
	endproperty
	a_sq_sel: assert property (p_sq_sel) else $error("Noise select wrong"); // [RULE_22]

	// Without a latch the decoded settings hold still.
	property p_hold;
		@(posedge clk_i) disable iff (reset_i)
		!latch_word ##1 !latch_word |=> $stable(mod_amp_o) && $stable(sq_thresh_o);
	endproperty
	a_hold: assert property (p_hold) else $error("Setting moved without latch"); // [RULE_25]

	// Main scenarios.
	c_latch: cover property (@(posedge clk_i) disable iff (reset_i) latch_word);
	c_rx: cover property (@(posedge clk_i) disable iff (reset_i) in_rx_sel_o && rx_out_en_o);
	c_bypass: cover property (@(posedge clk_i) disable iff (reset_i) post_powersave_o);
	c_mic: cover property (@(posedge clk_i) disable iff (reset_i) hp_gain_boost_o);
	c_sq: cover property (@(posedge clk_i) disable iff (reset_i) squelch_drive_o);

endmodule : audio_path_control_decoder

// ==== hdl/audio_path_pkg.sv ====
// Package with the control word layout, field codes and reset value of the audio path decoder.
// Behaviour
// RULE_01: Bit 0 picks microphone one or two.
// RULE_02: Bits 1-2 pick bias, microphone or receive.
// RULE_03: Bits 3-6 give input gain code.
// RULE_04: Bit 7 enables or bypasses the compressor.
// RULE_05: Host enables highpass whenever compressor is on.
// RULE_06: Bits 8-9 enable filters; mic adds gain.
// RULE_07: Bits 10-13 give pre-process gain code.
// RULE_08: Bit 14 picks internal or external post input.
// RULE_09: Bit 15 pre-emphasis, off under process bypass.
// RULE_10: Bit 16 picks narrow or wide lowpass.
// RULE_11: Bit 17 enables lowpass unless post powersaved.
// RULE_12: Bits 18-19 pick the output drive source.
// RULE_13: De-emphasis selected only on via-de-emphasis path.
// RULE_14: Process bypass powersaves the post path.
// RULE_15: Bits 20-22 give reference attenuation code.
// RULE_16: Bit 27 enables both modulation drive outputs.
// RULE_17: Bits 28-31 give modulator attenuation code.
// RULE_18: Bits 32-35 give modulator amplifier code.
// RULE_19: Bit 36 enables the receive audio output.
// RULE_20: Bits 37-40 set squelch filter gain, width.
// RULE_21: Bits 41-44 pick the squelch threshold.
// RULE_22: Bits 45-46 pick squelch source; 11 reserved.
// RULE_23: Host shifts 47 bits, bit 46 first.
// RULE_24: Data bits sampled on serial clock rise.
// RULE_25: Chip select rise latches the whole word.
// RULE_26: Squelch drive high when noise exceeds threshold.
// RULE_27: Bits 23-26 give reference amplifier code.
// RULE_28: Reset clears the active word to zero.
package audio_path_pkg;

	// Width of the serial control word.
	localparam int CTRL_W = 47;
	// Value of the active word after reset, all fields zero, so the test drive path is selected and the limiter runs.
	localparam logic [46:0] CTRL_RESET = 47'h0;

	// Lowest bit position of each field.
	localparam int B_MIC = 0;
	localparam int B_SRC = 1;
	localparam int B_IN_GAIN = 3;
	localparam int B_COMP = 7;
	localparam int B_HP = 8;
	localparam int B_LP = 9;
	localparam int B_PRE_GAIN = 10;
	localparam int B_PROC_SEL = 14;
	localparam int B_PREEMPH = 15;
	localparam int B_LPF_WIDE = 16;
	localparam int B_LPF_EN = 17;
	localparam int B_DRV = 18;
	localparam int B_REF_ATT = 20;
	localparam int B_REF_AMP = 23;
	localparam int B_OUT_EN = 27;
	localparam int B_MOD_ATT = 28;
	localparam int B_MOD_AMP = 32;
	localparam int B_RX_OUT = 36;
	localparam int B_SQ_GAIN = 37;
	localparam int B_SQ_WIDE = 40;
	localparam int B_SQ_THR = 41;
	localparam int B_SQ_SRC = 45;

	// Input source codes, written as {bit 2, bit 1}.
	localparam logic [1:0] SRC_BIAS = 2'h0;
	localparam logic [1:0] SRC_MIC = 2'h1;
	localparam logic [1:0] SRC_RX = 2'h2;
	localparam logic [1:0] SRC_BIAS_PS = 2'h3;

	// Output drive codes, written as {bit 19, bit 18}.
	localparam logic [1:0] DRV_TEST = 2'h0;
	localparam logic [1:0] DRV_DEEMPH = 2'h1;
	localparam logic [1:0] DRV_NO_DEEMPH = 2'h2;
	localparam logic [1:0] DRV_BYPASS = 2'h3;

	// Squelch source codes, written as {bit 46, bit 45}.
	localparam logic [1:0] SQ_BIAS = 2'h0;
	localparam logic [1:0] SQ_NOISE = 2'h1;
	localparam logic [1:0] SQ_RSSI = 2'h2;
	localparam logic [1:0] SQ_RESERVED = 2'h3;

	// Idle level of the active low chip select after reset.
	localparam logic CS_IDLE = 1'h1;

endpackage : audio_path_pkg

// ==== tb/audio_path_control_decoder_tb.sv ====
// Self-checking testbench for the audio path control decoder.
`timescale 1ns/1ps
module audio_path_control_decoder_tb;
	// Clock, reset and comparator input driven by the bench.
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic noise_above_i = 1'h0;
	// Link pins driven by the host model.
	logic serial_clk, serial_data, chip_sel_n;
	// Decoder outputs.
	logic mic2_sel_o, in_mic_sel_o, in_rx_sel_o, opamp_en_o, voice_level_compressor_en_o;
	logic hp_filter_en_o, hp_gain_boost_o, lp_filter_en_o, ext_proc_sel_o, preemph_en_o;
	logic limiter_en_o, post_lpf_wide_o, post_lpf_en_o, deemph_sel_o, post_powersave_o;
	logic out_drive_en_o, rx_out_en_o, sq_wide_o, sq_noise_sel_o, sq_rssi_sel_o;
	logic sq_detect_en_o, squelch_drive_o;
	logic [1:0] drive_sel_o;
	logic [2:0] ref_atten_o, sq_gain_o;
	logic [3:0] in_gain_o, pre_gain_o, ref_amp_o, mod_atten_o, mod_amp_o, sq_thresh_o;
	// All control outputs but the squelch drive packed in one vector for comparison.
	logic [52:0] act;
	int error_cnt = 0;
	int checks = 0;

	assign act = {mic2_sel_o, in_mic_sel_o, in_rx_sel_o, opamp_en_o, in_gain_o,
		voice_level_compressor_en_o, hp_filter_en_o, hp_gain_boost_o, lp_filter_en_o,
		pre_gain_o, ext_proc_sel_o, preemph_en_o, limiter_en_o, post_lpf_wide_o,
		post_lpf_en_o, drive_sel_o, deemph_sel_o, post_powersave_o, ref_atten_o, ref_amp_o,
		out_drive_en_o, mod_atten_o, mod_amp_o, rx_out_en_o, sq_gain_o, sq_wide_o,
		sq_thresh_o, sq_noise_sel_o, sq_rssi_sel_o, sq_detect_en_o};

	// System clock at 100 MHz.
	always #5 clk_i = ~clk_i;

	host_serial_model host (.serial_clk_o(serial_clk), .serial_data_o(serial_data),
		.chip_sel_n_o(chip_sel_n));

	audio_path_control_decoder #(.WORD_W(47)) DUT (.clk_i, .reset_i,
		.serial_clk_i(serial_clk), .serial_data_i(serial_data), .chip_sel_n_i(chip_sel_n),
		.noise_above_i, .mic2_sel_o, .in_mic_sel_o, .in_rx_sel_o, .opamp_en_o, .in_gain_o,
		.voice_level_compressor_en_o, .hp_filter_en_o, .hp_gain_boost_o, .lp_filter_en_o,
		.pre_gain_o, .ext_proc_sel_o, .preemph_en_o, .limiter_en_o, .post_lpf_wide_o,
		.post_lpf_en_o, .drive_sel_o, .deemph_sel_o, .post_powersave_o, .ref_atten_o,
		.ref_amp_o, .out_drive_en_o, .mod_atten_o, .mod_amp_o, .rx_out_en_o, .sq_gain_o,
		.sq_wide_o, .sq_thresh_o, .sq_noise_sel_o, .sq_rssi_sel_o, .sq_detect_en_o,
		.squelch_drive_o);

	// Expected control outputs for a latched word.
	function automatic logic [52:0] exp_of(input logic [46:0] w);
		logic [1:0] src;
		logic [1:0] drv;
		logic [1:0] sq;
		logic byp;
		src = w[2:1];
		drv = w[19:18];
		sq = w[46:45];
		byp = (drv == audio_path_pkg::DRV_BYPASS);
		return {w[0], src == 2'h1, src == 2'h2, src == 2'h1, w[6:3], w[7], w[8],
			w[8] & (src == 2'h1), w[9], w[13:10], w[14], w[15] & ~byp, ~byp, w[16],
			w[17] & ~byp, drv, drv == 2'h1, byp, w[22:20], w[26:23], w[27], w[31:28],
			w[35:32], w[36], w[39:37], w[40], w[44:41], sq == 2'h1, sq == 2'h2,
			(sq == 2'h1) | (sq == 2'h2)};
	endfunction : exp_of

	// Random legal word; the reserved squelch code is avoided.
	function automatic logic [46:0] rnd_word();
		logic [46:0] w;
		w = 47'({$urandom, $urandom});
		if (w[46:45] == 2'h3) w[46] = 1'h0;
		if (w[7]) w[8] = 1'h1;
		return w;
	endfunction : rnd_word

	// Compares the packed control outputs.
	task automatic cmp_word(input logic [52:0] exp);
		checks++;
		if (act !== exp) begin
			error_cnt++;
			$display("BAD t=%0t exp=%h act=%h", $time, exp, act);
		end
	endtask : cmp_word

	// Compares the squelch drive flag.
	task automatic cmp_flag(input logic exp);
		checks++;
		if (squelch_drive_o !== exp) begin
			error_cnt++;
			$display("BAD t=%0t exp=%h act=%h", $time, exp, squelch_drive_o);
		end
	endtask : cmp_flag

	// Loads one word; the old setting must stand until chip select rises.
	task automatic load(input logic [46:0] w, inout logic [46:0] cur);
		fork
			host.send(w, 1'b1);
			begin
				#960;
				cmp_word(exp_of(cur));
			end
		join
		repeat (2) @(posedge clk_i);
		#1;
		cmp_word(exp_of(w));
		cur = w;
	endtask : load

	// Prints the counts and the verdict, then ends the run.
	task automatic end_of_test();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	// Watchdog sized well beyond the roughly 32 us that the tests need.
	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end

	// Main sequence.
	initial begin
		logic [46:0] cur;
		logic [46:0] w;
		int k;
		k = $urandom(87);
		cur = 47'h0;
		repeat (20) @(posedge clk_i);
		reset_i <= 1'h0;
		#1;
		cmp_word(53'h0);
		// The all-zero word leaves the limiter running on the test path.
		repeat (2) @(posedge clk_i);
		#1;
		cmp_word(exp_of(47'h0));
		$display("reset test done");
		// Every source and drive code; the squelch source only takes its legal codes.
		for (k = 0; k < 4; k++) begin
			w = rnd_word();
			w[2:1] = k[1:0];
			w[19:18] = k[1:0];
			if (k < 3) w[46:45] = k[1:0];
			load(w, cur);
		end
		// All ones but bit 46, so the squelch source stays clear of the reserved code.
		load(47'h3fff_ffff_ffff, cur);
		load(47'h0, cur);
		$display("code test done");
		repeat (12) load(rnd_word(), cur);
		$display("random test done");
		// A reset in mid-run drops the active word back to all zeros.
		@(posedge clk_i);
		reset_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'h0;
		#1;
		cmp_word(53'h0);
		repeat (2) @(posedge clk_i);
		#1;
		cmp_word(exp_of(47'h0));
		cur = 47'h0;
		$display("mid-run reset test done");
		// Clocks with chip select high must leave the setting alone.
		host.send(rnd_word(), 1'b0);
		#1;
		cmp_word(exp_of(cur));
		$display("deselect test done");
		// Comparator result reaches the squelch drive after three clock edges.
		repeat (16) begin
			@(posedge clk_i);
			noise_above_i <= 1'($urandom);
			repeat (4) @(posedge clk_i);
			#1;
			cmp_flag(noise_above_i);
		end
		$display("squelch test done");
		end_of_test();
	end
endmodule : audio_path_control_decoder_tb

// ==== tb/host_serial_model.sv ====
// Host side model that shifts control words into the decoder over the three-wire link.
`timescale 1ns/1ps
module host_serial_model (
	// Three-wire link towards the decoder.
	output logic serial_clk_o,
	output logic serial_data_o,
	output logic chip_sel_n_o
);
	// All three pins idle at the level of their pull-ups; the link clock stands still.
	initial begin
		serial_clk_o = 1'h1;
		serial_data_o = 1'h1;
		chip_sel_n_o = 1'h1;
	end

	// Sends one whole word at a 32 ns bit period; sel low keeps chip select high.
	task automatic send(input logic [46:0] word, input bit sel);
		int i;
		#3;
		chip_sel_n_o = ~sel;
		#16;
		for (i = 46; i >= 0; i--) begin
			// Data moves on the falling edge, so it is steady at the sampling rise.
			serial_clk_o = 1'h0;
			serial_data_o = word[i];
			#16;
			serial_clk_o = 1'h1;
			#16;
		end
		// Chip select rises to latch, then data is released to its pull-up level.
		chip_sel_n_o = 1'h1;
		serial_data_o = 1'h1;
		// Quiet gap longer than the required spacing between frames.
		#80;
	endtask : send
endmodule : host_serial_model
